// file: shared/etp_pkg.sv
package etp_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_MODE   = 10'h0c0;
    localparam logic [9:0] IDX_COUNT  = 10'h0c1;
    localparam logic [9:0] IDX_RELOAD = 10'h0c2;
    localparam logic [9:0] IDX_DUTY   = 10'h0c3;
    localparam logic [9:0] IDX_CHAN   = 10'h0c4;
    localparam logic [9:0] IDX_EXT    = 10'h0c5;
    localparam logic [9:0] IDX_CTRL   = 10'h0c6;

    // timer_mode fields
    localparam int MODE_RUN_BIT   = 7;
    localparam int MODE_PRESC_LSB = 4;
    localparam int MODE_ONEP_BIT  = 1;
    localparam int MODE_PWMEN_BIT = 0;

    // channel, extension and control fields
    localparam int CHAN_LSB      = 4;
    localparam int EXT_LSB       = 2;
    localparam int CTRL_FLAG_BIT = 0;
    localparam int CTRL_IEN_BIT  = 1;
    localparam int CTRL_CKS_BIT  = 2;

    // reset values
    localparam logic [7:0] RST_MODE   = 8'h00;
    localparam logic [7:0] RST_COUNT  = 8'h00;
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic [7:0] RST_DUTY   = 8'h00;
    localparam logic [1:0] RST_CHAN   = 2'h0;
    localparam logic [1:0] RST_EXT    = 2'h0;

    localparam logic [7:0] FULL_SCALE = 8'hff;
    localparam int         PRESC_W    = 7;

    typedef struct packed {
        logic        run;
        logic [2:0]  presc;
        logic        onep;
        logic        pwm_en;
        logic [7:0]  count;
        logic [7:0]  reload;
        logic [7:0]  duty;
        logic [1:0]  chan;
        logic [1:0]  ext_sel;
        logic [1:0]  ext_act;
        logic [1:0]  phase;
        logic        comp;
        logic        flag;
        logic        ien;
        logic        cks;
        logic        pwm_lvl;
        logic        ack;
        logic [31:0] rdata;
    } etp_state_s;

endpackage

// file: shared/etp_tick_if.sv
`timescale 1ns/1ps
interface etp_tick_if;
    logic       src_en;
    logic [2:0] sel;
    logic       tick;
    modport timer  (output src_en, output sel, input tick);
    modport presc  (input src_en, input sel, output tick);
endinterface

// file: logic/etp_prescale.sv
`timescale 1ns/1ps
module etp_prescale (
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    // tick carrier
    etp_tick_if.presc   tk
);

    typedef struct packed {
        logic [etp_pkg::PRESC_W-1:0] cnt;
    } etp_presc_s;

    etp_presc_s st_ff;
    etp_presc_s nxt_st;

    function automatic logic [etp_pkg::PRESC_W-1:0] etp_mask(input logic [2:0] sel);
        etp_mask = {etp_pkg::PRESC_W{1'b1}} >> sel;
    endfunction

    // divide by 128 down to 1
    assign tk.tick = tk.src_en && ((st_ff.cnt & etp_mask(tk.sel)) == etp_mask(tk.sel));

    always_comb begin
        nxt_st = st_ff;
        if (tk.src_en) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    a_tick_src_only: assert property (@(posedge clk_i) disable iff (rst_i) tk.tick |-> tk.src_en)
        else $error("prescaler tick without source enable");
    // divide by one passes every edge
    a_div_one_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        (tk.sel == 3'h7 && tk.src_en) |-> tk.tick)
        else $error("divide by one dropped a tick");

endmodule // etp_prescale

// file: logic/etp_timer.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - counter holds while run is 0, counts up one per tick while 1.
// - rollover from 0xff to the reload value sets overflow flag; only software clears it.
// - every overflow reloads counter from reload register, no enable bit.
// - reload writes are buffered and take effect only at next overflow.
// - with irq enable set, overflow raises the interrupt request.
// - clock source bit picks instruction clock (0) or fast oscillator (1).
// - prescale field 000..111 divides by 128,64,32,16,8,4,2,1.
// - counter spans 256 steps, one step per prescaled tick.
// - pwm enable 0 leaves pins gpio; 1 drives pwm on selected pins while run is 1.
// - each channel bit switches its pin to pwm; clear returns gpio.
// - one-pulse mode: one cycle, then flag set, pwm enable cleared.
// - extension builds period from four phases; off in one-pulse mode.
// - green mode keeps everything running, never wakes the system.
// - pwm high from reload, low when count equals duty, ends at overflow.
// - extension 00/01/10/11 adds counts in phases none/1/1,3/1,2,3; new setting after phase 3.
module etp_timer (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [11:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output wire logic [31:0] dat_o,
    output wire logic        ack_o,
    // timer clock sources, one-cycle enables
    input  wire logic        fcpu_en_i,
    input  wire logic        fhosc_en_i,
    // gpio state of the shared pins
    input  wire logic [1:0]  gpio_out_i,
    input  wire logic [1:0]  gpio_oe_i,
    // shared pins and interrupt
    output wire logic [1:0]  pwm_pin_o,
    output wire logic [1:0]  pwm_pin_oe_o,
    output wire logic        irq_o
);

    etp_pkg::etp_state_s st_ff;
    etp_pkg::etp_state_s nxt_st;

    logic       req;
    logic       wr;
    logic       ovf;
    logic [9:0] idx;
    logic       wr_count;
    logic       wr_ctrl;
    logic       wr_mode;
    logic       need_comp;
    logic [1:0] chan_on;

    etp_tick_if tk ();

    etp_prescale u_presc (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tk    (tk)
    );

    function automatic logic etp_comp_phase(input logic [1:0] sel, input logic [1:0] ph);
        logic r;
        r = 1'b0;
        unique case (sel)
            2'h0: r = 1'b0;
            2'h1: r = (ph == 2'h1);
            2'h2: r = (ph == 2'h1) || (ph == 2'h3);
            2'h3: r = (ph != 2'h0);
        endcase
        return r;
    endfunction

    function automatic logic [31:0] etp_read(input etp_pkg::etp_state_s s, input logic [9:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == etp_pkg::IDX_MODE) begin
            r[etp_pkg::MODE_RUN_BIT]                      = s.run;
            r[etp_pkg::MODE_PRESC_LSB +: 3]               = s.presc;
            r[etp_pkg::MODE_ONEP_BIT]                     = s.onep;
            r[etp_pkg::MODE_PWMEN_BIT]                    = s.pwm_en;
        end else if (a == etp_pkg::IDX_COUNT) begin
            r[7:0] = s.count;
        end else if (a == etp_pkg::IDX_DUTY) begin
            r[7:0] = s.duty;
        end else if (a == etp_pkg::IDX_CHAN) begin
            r[etp_pkg::CHAN_LSB +: 2] = s.chan;
        end else if (a == etp_pkg::IDX_EXT) begin
            r[etp_pkg::EXT_LSB +: 2] = s.ext_sel;
        end else if (a == etp_pkg::IDX_CTRL) begin
            r[etp_pkg::CTRL_FLAG_BIT] = s.flag;
            r[etp_pkg::CTRL_IEN_BIT]  = s.ien;
            r[etp_pkg::CTRL_CKS_BIT]  = s.cks;
        end
        return r;
    endfunction

    assign tk.src_en = st_ff.cks ? fhosc_en_i : fcpu_en_i;
    assign tk.sel    = st_ff.presc;

    assign req      = cyc_i && stb_i && !st_ff.ack;
    assign wr       = req && we_i && sel_i[0];
    assign idx      = adr_i[11:2];
    assign wr_count = wr && (idx == etp_pkg::IDX_COUNT);
    assign wr_ctrl  = wr && (idx == etp_pkg::IDX_CTRL);
    assign wr_mode  = wr && (idx == etp_pkg::IDX_MODE);

    assign need_comp = !st_ff.onep && etp_comp_phase(st_ff.ext_act, st_ff.phase);

    always_comb begin
        nxt_st     = st_ff;
        nxt_st.ack = req;
        ovf        = 1'b0;
        // green mode changes nothing here, no wake path exists
        if (st_ff.run && tk.tick) begin
            if (st_ff.count == etp_pkg::FULL_SCALE) begin
                // one extra high count before rollover
                if (need_comp && !st_ff.comp) begin
                    nxt_st.comp    = 1'b1;
                    nxt_st.pwm_lvl = 1'b1;
                end else begin
                    ovf         = 1'b1;
                    nxt_st.comp = 1'b0;
                end
            end else begin
                nxt_st.count = st_ff.count + 8'h01;
                if (nxt_st.count == st_ff.duty) begin
                    nxt_st.pwm_lvl = 1'b0;
                end
            end
        end
        if (ovf) begin
            // buffered reload value only used here
            nxt_st.count = st_ff.reload;
            nxt_st.flag  = 1'b1;
            // duty not above reload keeps it low
            nxt_st.pwm_lvl = (st_ff.duty > st_ff.reload);
            nxt_st.phase = st_ff.phase + 2'h1;
            // new extension only after full four phases
            if (st_ff.phase == 2'h3) begin
                nxt_st.ext_act = st_ff.ext_sel;
            end
            if (st_ff.onep && st_ff.pwm_en) begin
                nxt_st.pwm_en = 1'b0;
            end
        end
        if (wr) begin
            if (idx == etp_pkg::IDX_MODE) begin
                nxt_st.run    = dat_i[etp_pkg::MODE_RUN_BIT];
                nxt_st.presc  = dat_i[etp_pkg::MODE_PRESC_LSB +: 3];
                nxt_st.onep   = dat_i[etp_pkg::MODE_ONEP_BIT];
                nxt_st.pwm_en = dat_i[etp_pkg::MODE_PWMEN_BIT];
            end else if (idx == etp_pkg::IDX_COUNT) begin
                nxt_st.count = dat_i[7:0];
            end else if (idx == etp_pkg::IDX_RELOAD) begin
                nxt_st.reload = dat_i[7:0];
            end else if (idx == etp_pkg::IDX_DUTY) begin
                nxt_st.duty = dat_i[7:0];
            end else if (idx == etp_pkg::IDX_CHAN) begin
                nxt_st.chan = dat_i[etp_pkg::CHAN_LSB +: 2];
            end else if (idx == etp_pkg::IDX_EXT) begin
                nxt_st.ext_sel = dat_i[etp_pkg::EXT_LSB +: 2];
            end else if (idx == etp_pkg::IDX_CTRL) begin
                nxt_st.flag = ovf || (st_ff.flag && dat_i[etp_pkg::CTRL_FLAG_BIT]);
                nxt_st.ien  = dat_i[etp_pkg::CTRL_IEN_BIT];
                nxt_st.cks  = dat_i[etp_pkg::CTRL_CKS_BIT];
            end
        end
        nxt_st.rdata = req ? etp_read(st_ff, idx) : 32'h0000_0000;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff         <= '0;
            st_ff.run     <= etp_pkg::RST_MODE[etp_pkg::MODE_RUN_BIT];
            st_ff.presc   <= etp_pkg::RST_MODE[etp_pkg::MODE_PRESC_LSB +: 3];
            st_ff.onep    <= etp_pkg::RST_MODE[etp_pkg::MODE_ONEP_BIT];
            st_ff.pwm_en  <= etp_pkg::RST_MODE[etp_pkg::MODE_PWMEN_BIT];
            st_ff.count   <= etp_pkg::RST_COUNT;
            st_ff.reload  <= etp_pkg::RST_RELOAD;
            st_ff.duty    <= etp_pkg::RST_DUTY;
            st_ff.chan    <= etp_pkg::RST_CHAN;
            st_ff.ext_sel <= etp_pkg::RST_EXT;
            st_ff.ext_act <= etp_pkg::RST_EXT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // pwm only with enable and run
    assign chan_on      = {2{st_ff.pwm_en && st_ff.run}} & st_ff.chan;
    assign pwm_pin_o    = (chan_on & {2{st_ff.pwm_lvl}}) | (~chan_on & gpio_out_i);
    assign pwm_pin_oe_o = chan_on | gpio_oe_i;

    assign irq_o = st_ff.flag && st_ff.ien;
    assign dat_o = st_ff.rdata;
    assign ack_o = st_ff.ack;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_count_hold: assert property (!st_ff.run && !wr_count |=> $stable(st_ff.count))
        else $error("counter moved while stopped");
    a_count_step: assert property (st_ff.run && tk.tick && st_ff.count != 8'hff && !wr_count
        |=> st_ff.count == $past(st_ff.count) + 8'h01)
        else $error("counter did not step by one");
    a_ovf_sets_flag: assert property (ovf |=> st_ff.flag)
        else $error("overflow did not set flag");
    a_flag_set_wins: assert property (ovf && wr_ctrl && !dat_i[0] |=> st_ff.flag)
        else $error("clear beat a coinciding overflow");
    a_flag_stays_set: assert property (st_ff.flag && !wr_ctrl |=> st_ff.flag)
        else $error("flag cleared without software");
    a_reload_on_ovf: assert property (ovf && !wr_count |=> st_ff.count == $past(st_ff.reload))
        else $error("counter not reloaded at overflow");
    a_reload_buffered: assert property (!ovf && !wr_count && st_ff.run && !tk.tick
        |=> $stable(st_ff.count))
        else $error("reload write disturbed running count");
    a_irq_on_ovf: assert property (ovf && st_ff.ien && !wr_ctrl |=> irq_o [*2])
        else $error("enabled overflow raised no request");
    a_one_pulse_end: assert property (ovf && st_ff.onep && st_ff.pwm_en && !wr_mode
        |=> !st_ff.pwm_en && pwm_pin_oe_o == gpio_oe_i)
        else $error("one pulse did not end at overflow");
    a_pwm_cycle_high: assert property (ovf && st_ff.duty > st_ff.reload |=> st_ff.pwm_lvl)
        else $error("pwm cycle did not start high");
    a_gpio_when_off: assert property (!st_ff.pwm_en
        |-> pwm_pin_o == gpio_out_i && pwm_pin_oe_o == gpio_oe_i)
        else $error("pins not gpio with pwm disabled");
    a_comp_then_ovf: assert property (st_ff.comp && st_ff.run && tk.tick |-> ovf)
        else $error("extra count did not end in overflow");
    a_no_comp_onep: assert property (st_ff.onep |-> !need_comp)
        else $error("extension active in one-pulse mode");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    c_overflow: cover property (ovf);
    c_one_pulse: cover property (ovf && st_ff.onep && st_ff.pwm_en);
    c_ext_comp: cover property (st_ff.comp && ovf);
    c_set_vs_clr: cover property (ovf && wr_ctrl);

endmodule // etp_timer

// file: test/etp_timer_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module etp_timer_test;
    // clock, reset and bus
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0]  sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0;
    wire  [31:0] dat_o;
    wire         ack_o;
    // sources, gpio and pins
    logic        fcpu_en_i = 1'b0;
    logic        fhosc_en_i = 1'b0;
    logic [1:0]  gpio_out_i = 2'h0;
    logic [1:0]  gpio_oe_i = 2'h0;
    wire  [1:0]  pwm_pin_o;
    wire  [1:0]  pwm_pin_oe_o;
    wire         irq_o;
    integer      seed = 32'h70ee;
    int          mismatches = 0;
    int          compares = 0;
    logic [31:0] rd;
    int          m_cnt;
    logic        m_lvl;
    logic [1:0]  m_act;
    int          regs[$] = '{'h0c0, 'h0c1, 'h0c2, 'h0c3, 'h0c4, 'h0c5, 'h0c6, 'h0d0};

    etp_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .fcpu_en_i(fcpu_en_i), .fhosc_en_i(fhosc_en_i), .gpio_out_i(gpio_out_i),
        .gpio_oe_i(gpio_oe_i), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe_o(pwm_pin_oe_o), .irq_o(irq_o));

    always #50 clk_i = ~clk_i;

    // gpio state wanders so pin muxing is seen
    always @(posedge clk_i) begin
        gpio_out_i <= 2'($random(seed));
        gpio_oe_i <= 2'($random(seed));
    end

    task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask

    task automatic rc(input logic [9:0] idx, input logic [31:0] e);
        wb(1'b0, idx, 8'h00);
        `CHK("register", e, rd)
    endtask

    // unselected source toggles randomly; it must be ignored
    task automatic pulse(input int n, input logic cks);
        repeat (n) begin
            @(posedge clk_i);
            fcpu_en_i <= cks ? 1'($random(seed)) : 1'b1;
            fhosc_en_i <= cks ? 1'b1 : 1'($random(seed));
        end
        @(posedge clk_i);
        fcpu_en_i <= 1'b0;
        fhosc_en_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic pins(input logic [1:0] act, input logic lvl);
        @(negedge clk_i);
        for (int i = 0; i < 2; i++) begin
            `CHK("pin level", act[i] ? lvl : gpio_out_i[i], pwm_pin_o[i])
            `CHK("pin enable", act[i] ? 1'b1 : gpio_oe_i[i], pwm_pin_oe_o[i])
        end
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (regs[i]) rc(10'(regs[i]), 32'h0);
        wr(etp_pkg::IDX_RELOAD, 8'h5a);
        rc(etp_pkg::IDX_RELOAD, 32'h0);
        wr(10'h0d0, 8'h77);
        rc(10'h0d0, 32'h0);
        // any 2*div source pulses give exactly two ticks, whatever the phase
        for (int c = 0; c < 2; c++) begin
            for (int p = 0; p < 8; p++) begin
                wr(etp_pkg::IDX_CTRL, 8'(c << 2));
                wr(etp_pkg::IDX_COUNT, 8'h00);
                wr(etp_pkg::IDX_MODE, 8'h80 | 8'(p << 4));
                pulse(2 * (128 >> p), 1'(c));
                wr(etp_pkg::IDX_MODE, 8'(p << 4));
                rc(etp_pkg::IDX_COUNT, 32'h2);
                pulse(5, 1'(c));
                rc(etp_pkg::IDX_COUNT, 32'h2);
            end
        end
        wr(etp_pkg::IDX_CTRL, 8'h02);
        wr(etp_pkg::IDX_COUNT, 8'hfe);
        wr(etp_pkg::IDX_RELOAD, 8'hfe);
        wr(etp_pkg::IDX_MODE, 8'hf0);
        pulse(2, 1'b0);
        rc(etp_pkg::IDX_COUNT, 32'hfe);
        rc(etp_pkg::IDX_CTRL, 32'h03);
        `CHK("irq", 1'b1, irq_o)
        wr(etp_pkg::IDX_RELOAD, 8'h10);
        pulse(1, 1'b0);
        rc(etp_pkg::IDX_COUNT, 32'hff);
        pulse(1, 1'b0);
        rc(etp_pkg::IDX_COUNT, 32'h10);
        wr(etp_pkg::IDX_CTRL, 8'h02);
        rc(etp_pkg::IDX_CTRL, 32'h02);
        `CHK("irq", 1'b0, irq_o)
        wr(etp_pkg::IDX_CTRL, 8'h00);
        wr(etp_pkg::IDX_COUNT, 8'hfe);
        pulse(2, 1'b0);
        `CHK("irq", 1'b0, irq_o)
        // writing flag bit as one keeps the pending flag
        wr(etp_pkg::IDX_CTRL, 8'h03);
        `CHK("irq", 1'b1, irq_o)
        wr(etp_pkg::IDX_CTRL, 8'h00);
        // two pwm periods from reload 0xf0 with duty 0xf4
        // mode set before run
        wr(etp_pkg::IDX_MODE, 8'h70);
        wr(etp_pkg::IDX_RELOAD, 8'hf0);
        wr(etp_pkg::IDX_COUNT, 8'hff);
        wr(etp_pkg::IDX_DUTY, 8'hf4);
        wr(etp_pkg::IDX_CHAN, 8'h10);
        wr(etp_pkg::IDX_MODE, 8'hf1);
        m_cnt = 'hff;
        m_act = 2'b01;
        for (int k = 0; k < 34; k++) begin
            if (k == 17) begin
                wr(etp_pkg::IDX_CHAN, 8'h30);
                m_act = 2'b11;
            end
            pulse(1, 1'b0);
            if (m_cnt == 'hff) begin
                m_cnt = 'hf0;
                m_lvl = 1'b1;
            end else begin
                m_cnt++;
                if (m_cnt == 'hf4) m_lvl = 1'b0;
            end
            pins(m_act, m_lvl);
        end
        wr(etp_pkg::IDX_MODE, 8'hf0);
        pins(2'b00, 1'b0);
        wr(etp_pkg::IDX_MODE, 8'hf1);
        wr(etp_pkg::IDX_CHAN, 8'h00);
        pins(2'b00, 1'b0);
        // single pulse ends at the overflow
        wr(etp_pkg::IDX_CHAN, 8'h30);
        wr(etp_pkg::IDX_COUNT, 8'hfe);
        wr(etp_pkg::IDX_MODE, 8'hf3);
        pulse(2, 1'b0);
        rc(etp_pkg::IDX_MODE, 32'hf2);
        rc(etp_pkg::IDX_CTRL, 32'h01);
        pins(2'b00, 1'b0);
        end_of_test();
    end
endmodule // etp_timer_test
